// ---- src/sac_pkg.sv ----
// Purpose: Shared constants for the converter control block
// Assumes: 32-bit AXI4-Lite data, byte-wide registers in the low lane
// Notes: Offsets are byte addresses, one aligned word each
package sac_pkg;
    // ==================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_RES_LOW = 8'h0C;
    localparam logic [7:0] OFS_RES_HIGH = 8'h10;
    localparam logic [7:0] OFS_POWER = 8'h14;
    // ==================================================
    // Field positions
    localparam int CA_ENABLE = 7;
    localparam int CA_START = 6;
    localparam int CA_AUTO = 5;
    localparam int CA_FLAG = 4;
    localparam int CA_IE = 3;
    localparam int SEL_LEFT = 5;
    localparam int PWR_OFF = 0;
    // ==================================================
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic PWR_OFF_RST = 1'b0;
    // ==================================================
    // Timing in converter clock cycles
    localparam logic [4:0] CONV_NORMAL = 5'd13;
    localparam logic [4:0] CONV_FIRST = 5'd25;
    localparam logic [4:0] SAMPLE_NORMAL = 5'd1;
    localparam logic [4:0] SAMPLE_FIRST = 5'd13;
    localparam int PRESCALE_DIV = 8;
    // ==================================================
    // Channel groups, gain, trigger and response codes
    localparam logic [4:0] CH_DIFF_LO = 5'h08;
    localparam logic [4:0] CH_G200_LO = 5'h0C;
    localparam logic [4:0] CH_G1_LO = 5'h10;
    localparam logic [4:0] CH_BANDGAP = 5'h1E;
    localparam logic [1:0] GAIN_BYPASS = 2'h0;
    localparam logic [1:0] GAIN_1X = 2'h1;
    localparam logic [1:0] GAIN_10X = 2'h2;
    localparam logic [1:0] GAIN_200X = 2'h3;
    localparam logic [2:0] TRIG_SELF = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==================================================
    // Sequencer states, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CONV = 2'b11
    } sac_state_t;
endpackage

// ---- src/sac_prescaler.sv ----
// Purpose: Converter clock enable divider
// Assumes: One system clock
// Notes: Held cleared while stopped or restarted
`timescale 1ns/1ps
module sac_prescaler #(
    parameter int DIV = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic run,
    input wire logic restart,
    // Enable pulse
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_q;

    // ==================================================
    // Counter
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || restart) begin
            cnt_q <= '0;
        end else if (cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = run && !restart && (cnt_q == LAST);
endmodule // sac_prescaler

// ---- src/sac_top.sv ----
// Purpose: Sequencing, register file and result handling for a 10-bit converter
// Assumes: AXI4-Lite register access, inputs synchronous to aclk
// Notes: Analog core is driven through strobes; result taken at done
`timescale 1ns/1ps
// Notes on behaviour
// - Power-off bit keeps converter disabled
// - Enable bit powers converter; clear stops all
// - Selections reach core only while enabled
// - Five-bit field picks input, ground, bandgap
// - Differential pairs use gain; single-ended bypass
// - Result right aligned, left when adjust set
// - Low byte read blocks result updates
// - Blocked completion discards the new result
// - High byte read re-enables result updates
// - Completion flag set even when result discarded
// - Start bit high during conversion, cleared after
// - Channel change waits for conversion end
// - Auto enable and source field select trigger
// - Trigger rising edge restarts prescaler, converts
// - Held trigger level starts no new conversion
// - Trigger edges during conversion are ignored
// - Trigger flags set regardless of interrupt enables
// - Self source free runs after first start
// - Start bit works with auto triggering on
// - Start bit reads one in every conversion
// - Normal conversion 13 cycles, first 25
// - Completion writes result unless blocked, always sets flag
// - Prescaler runs only while enabled
module sac_top
    import sac_pkg::*;
#(
    parameter int DIV = PRESCALE_DIV
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Trigger sources, bit 0 unused
    input wire logic [7:0] trig_in,
    // Analog core
    input wire logic [9:0] core_data,
    output logic core_power,
    output logic core_start,
    output logic core_sample,
    output logic core_done,
    output logic [4:0] core_channel,
    output logic [1:0] core_reference,
    output logic [1:0] core_gain,
    // Completion interrupt
    output logic conv_irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_full;
        logic w_full;
        logic [7:0] awaddr;
        logic [7:0] wdata;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic en;
        logic start;
        logic auto;
        logic flag;
        logic ie;
        logic [2:0] src;
        logic [1:0] ref_sel;
        logic left;
        logic [4:0] chan;
        logic pwr_off;
        logic [9:0] result;
        logic locked;
        logic first;
        logic trig_prev;
        sac_state_t st;
        logic [4:0] cnt;
        logic core_power;
        logic core_start;
        logic core_sample;
        logic core_done;
        logic [4:0] core_channel;
        logic [1:0] core_reference;
        logic [1:0] core_gain;
        logic irq;
    } sac_regs_t;

    sac_regs_t s, n;
    logic tick, restart, done_now, wr_go, rd_go, sw_start, clr_flag, en_eff, trig_lvl, trig_edge;
    logic [4:0] len, samp;

    // ==================================================
    // Converter clock divider
    sac_prescaler #(.DIV(DIV)) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(s.core_power),
        .restart(restart),
        .tick(tick)
    );

    // ==================================================
    // Gain selection from channel code
    function automatic logic [1:0] gain_of(input logic [4:0] ch);
        logic [1:0] g;
        g = GAIN_BYPASS;
        if (ch >= CH_BANDGAP) g = GAIN_BYPASS;
        else if (ch >= CH_G1_LO) g = GAIN_1X;
        else if (ch >= CH_G200_LO) g = GAIN_200X;
        else if (ch >= CH_DIFF_LO) g = GAIN_10X;
        return g;
    endfunction

    // ==================================================
    // Register read value
    function automatic logic [7:0] read_of(input sac_regs_t r, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_CTRL_A: v = {r.en, r.start || (r.st != ST_IDLE), r.auto, r.flag, r.ie, 3'b000};
            OFS_CTRL_B: v = {5'b00000, r.src};
            OFS_SEL: v = {r.ref_sel, r.left, r.chan};
            OFS_RES_LOW: v = r.left ? {r.result[1:0], 6'b000000} : r.result[7:0];
            OFS_RES_HIGH: v = r.left ? r.result[9:2] : {6'b000000, r.result[9:8]};
            OFS_POWER: v = {7'b0000000, r.pwr_off};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_SEL) || (a == OFS_RES_LOW)
            || (a == OFS_RES_HIGH) || (a == OFS_POWER);
    endfunction

    // ==================================================
    // Next state
    always_comb begin
        n = s;
        sw_start = 1'b0;
        clr_flag = 1'b0;
        restart = 1'b0;
        done_now = 1'b0;
        n.core_start = 1'b0;
        n.core_sample = 1'b0;
        n.core_done = 1'b0;
        // Write channel
        if (s_axi_awvalid && s.awready) begin
            n.aw_full = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.w_full = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wlane = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) n.bvalid = 1'b0;
        wr_go = s.aw_full && s.w_full && !s.bvalid;
        if (wr_go) begin
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s.wlane) begin
                case (s.awaddr)
                    OFS_CTRL_A: begin
                        n.en = s.wdata[CA_ENABLE];
                        sw_start = s.wdata[CA_START];
                        n.auto = s.wdata[CA_AUTO];
                        clr_flag = s.wdata[CA_FLAG];
                        n.ie = s.wdata[CA_IE];
                    end
                    OFS_CTRL_B: n.src = s.wdata[2:0];
                    OFS_SEL: begin
                        n.ref_sel = s.wdata[7:6];
                        n.left = s.wdata[SEL_LEFT];
                        n.chan = s.wdata[4:0];
                    end
                    OFS_POWER: n.pwr_off = s.wdata[PWR_OFF];
                    default: n.pwr_off = n.pwr_off;
                endcase
            end
        end
        n.awready = !n.aw_full && !n.bvalid;
        n.wready = !n.w_full && !n.bvalid;
        // Read channel
        if (s.rvalid && s_axi_rready) n.rvalid = 1'b0;
        rd_go = s_axi_arvalid && s.arready;
        if (rd_go) begin
            n.rvalid = 1'b1;
            n.rdata = read_of(s, s_axi_araddr);
            n.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == OFS_RES_LOW) n.locked = 1'b1;
            if (s_axi_araddr == OFS_RES_HIGH) n.locked = 1'b0;
        end
        n.arready = !n.rvalid;
        if (clr_flag) n.flag = 1'b0;
        // Enable gating
        en_eff = n.en && !n.pwr_off;
        sw_start = sw_start && en_eff;
        if (sw_start) n.start = 1'b1;
        // Trigger edge
        trig_lvl = (s.src == TRIG_SELF) ? s.flag : trig_in[s.src];
        n.trig_prev = trig_lvl;
        trig_edge = trig_lvl && !s.trig_prev;
        len = s.first ? CONV_FIRST : CONV_NORMAL;
        samp = s.first ? SAMPLE_FIRST : SAMPLE_NORMAL;
        // Sequencer
        case (s.st)
            ST_IDLE: begin
                if (s.auto && trig_edge && s.src != TRIG_SELF && s.core_power) begin
                    restart = 1'b1;
                    n.st = ST_CONV;
                    n.cnt = 5'd0;
                    n.core_start = 1'b1;
                end else if (sw_start) begin
                    n.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick) begin
                    n.st = ST_CONV;
                    n.cnt = 5'd0;
                    n.core_start = 1'b1;
                end
            end
            ST_CONV: begin
                // Further edges are dropped here
                if (tick) begin
                    if (s.cnt == samp) n.core_sample = 1'b1;
                    if (s.cnt == len - 5'd1) done_now = 1'b1;
                    else n.cnt = s.cnt + 5'd1;
                end
            end
            default: n.st = ST_IDLE;
        endcase
        if (done_now) begin
            n.core_done = 1'b1;
            n.flag = 1'b1;
            n.first = 1'b0;
            if (!s.locked) n.result = core_data;
            if (s.auto && s.src == TRIG_SELF) begin
                n.st = ST_CONV;
                n.cnt = 5'd0;
                n.core_start = 1'b1;
            end else begin
                n.st = ST_IDLE;
                n.start = 1'b0;
            end
        end
        // Selections reach the core only between conversions
        if (en_eff && (s.st != ST_CONV || done_now)) begin
            n.core_channel = n.chan;
            n.core_reference = n.ref_sel;
            n.core_gain = gain_of(n.chan);
        end
        if (!en_eff) begin
            n.st = ST_IDLE;
            n.start = 1'b0;
            n.first = 1'b1;
            n.cnt = 5'd0;
            n.core_start = 1'b0;
            n.core_sample = 1'b0;
            n.core_done = 1'b0;
        end
        n.core_power = en_eff;
        n.irq = n.flag && n.ie;
    end

    // ==================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.first <= 1'b1;
            s.pwr_off <= PWR_OFF_RST;
            s.st <= ST_IDLE;
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = {24'h00_0000, s.rdata};
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign core_power = s.core_power;
    assign core_start = s.core_start;
    assign core_sample = s.core_sample;
    assign core_done = s.core_done;
    assign core_channel = s.core_channel;
    assign core_reference = s.core_reference;
    assign core_gain = s.core_gain;
    assign conv_irq = s.irq;

    // ==================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence trig_seen;
        s.st == ST_IDLE && s.auto && trig_edge && s.src != TRIG_SELF && s.core_power && en_eff;
    endsequence
    sequence conv_begun;
        s.st == ST_CONV && s.core_start && s.cnt == 5'd0;
    endsequence

    a_power_gate: assert property (s.pwr_off |-> !s.core_power)
        else $error("converter powered while power-off set");
    a_start_busy: assert property (rd_go && s_axi_araddr == OFS_CTRL_A && s.st == ST_CONV
        |=> s.rdata[CA_START])
        else $error("start bit low during conversion");
    a_chan_held: assert property (s.st == ST_CONV && $past(s.st) == ST_CONV && !s.core_done
        |-> $stable(s.core_channel))
        else $error("channel changed mid conversion");
    a_trig_start: assert property (trig_seen |=> conv_begun)
        else $error("trigger edge did not start conversion");
    a_lock_keeps: assert property (s.core_done && $past(s.locked) |-> s.result == $past(s.result))
        else $error("blocked result was overwritten");
    a_flag_done: assert property (s.core_done |-> s.flag)
        else $error("completion flag not set");
    a_len_normal: assert property (s.core_done && !$past(s.first) |-> $past(s.cnt) == CONV_NORMAL - 5'd1)
        else $error("normal conversion length wrong");
    a_len_first: assert property (s.core_done && $past(s.first) |-> $past(s.cnt) == CONV_FIRST - 5'd1)
        else $error("first conversion length wrong");
    a_lock_read: assert property (rd_go && s_axi_araddr == OFS_RES_LOW |=> s.locked)
        else $error("low byte read did not block");
    a_unlock_read: assert property (rd_go && s_axi_araddr == OFS_RES_HIGH |=> !s.locked)
        else $error("high byte read did not unblock");
    a_free_run: assert property (done_now && s.auto && s.src == TRIG_SELF && en_eff |=> conv_begun)
        else $error("free running did not restart");
endmodule // sac_top

// ---- tb/sac_core_model.sv ----
// Purpose: Behavioural analog core and input multiplexer
// Assumes: Result is the latched channel and a bench-given level
// Notes: Unpowered core drives a toggling pattern on its data
`timescale 1ns/1ps
module sac_core_model
    import sac_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Control from the block
    input wire logic core_power,
    input wire logic core_sample,
    input wire logic [4:0] core_channel,
    // Analog level from the bench
    input wire logic [4:0] level,
    // Result
    output logic [9:0] core_data
);
    // ==================================================
    // Sample and hold
    logic [9:0] held_q = 10'h0;
    logic [9:0] junk_q = 10'h2AA;
    always_ff @(posedge aclk) begin
        if (core_sample) begin
            held_q <= {core_channel, level};
        end
        junk_q <= ~junk_q;
    end
    assign core_data = core_power ? held_q : junk_q;
endmodule // sac_core_model

// ---- tb/sac_top_tb_top.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Small prescaler division keeps runs short
// Notes: Reads are queued by the driver and checked by a monitor
`timescale 1ns/1ps
module sac_top_tb_top
    import sac_pkg::*;
;
    localparam int DV = 2;
    localparam int NRM = 13 * DV;
    localparam int FST = 25 * DV;
    // ==================================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, trig_in = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] ain = 5'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic core_power, core_start, core_sample, core_done, conv_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, core_reference, core_gain;
    logic [31:0] s_axi_rdata, x, last;
    logic [9:0] core_data, v;
    logic [4:0] core_channel;
    logic [34:0] re;
    logic [34:0] rq[$];
    logic [1:0] bq[$];
    int n = 0, len = 0, nst = 0, ndn = 0, s0 = 0, num_errors = 0, total_checks = 0;
    logic [4:0] chs [6] = '{5'h00, CH_DIFF_LO, CH_G200_LO, CH_G1_LO, CH_BANDGAP, 5'h1F};
    logic [1:0] gns [6] = '{GAIN_BYPASS, GAIN_10X, GAIN_200X, GAIN_1X, GAIN_BYPASS, GAIN_BYPASS};
    always #5 aclk = ~aclk;
    // ==================================================
    // Design and partner
    sac_top #(.DIV(DV)) sac_top_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .trig_in, .core_data, .core_power, .core_start, .core_sample, .core_done, .core_channel,
        .core_reference, .core_gain, .conv_irq
    );
    sac_core_model sac_core_model_i (
        .aclk, .core_power, .core_sample, .core_channel, .level(ain), .core_data
    );
    // ==================================================
    // Checks and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkr(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk(nm, 32'(e), 32'(g));
    endtask
    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic u = 1'b1,
                      input logic [1:0] r = RESP_OKAY);
        rq.push_back({u, r, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        last = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wdn(input int k = 1);
        int n0;
        n0 = ndn;
        for (int i = 0; i < 4000 && ndn < n0 + k; i++) @(posedge aclk);
        chk("done count", 32'(n0 + k), 32'(ndn));
    endtask
    task automatic newv;
        x = $urandom;
        ain <= x[4:0];
    endtask
    function automatic logic [31:0] lo(input logic [9:0] d, input logic l);
        return l ? {24'h0, d[1:0], 6'h0} : {24'h0, d[7:0]};
    endfunction
    function automatic logic [31:0] hi(input logic [9:0] d, input logic l);
        return l ? {24'h0, d[9:2]} : {30'h0, d[9:8]};
    endfunction
    // ==================================================
    // Monitor
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            re = rq.pop_front();
            if (re[34]) chk("rdata", re[31:0], s_axi_rdata);
            chkr("rresp", re[33:32], s_axi_rresp);
        end
        if (s_axi_bvalid && s_axi_bready) chkr("bresp", bq.pop_front(), s_axi_bresp);
        if (core_start) begin
            n <= 0;
            nst <= nst + 1;
        end else begin
            n <= n + 1;
        end
        if (core_done) begin
            len <= n + 1;
            ndn <= ndn + 1;
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        summarize();
    end
    // ==================================================
    // Tests
    initial begin
        x = $urandom(32'h8852_41E9);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFS_CTRL_A, 32'h0);
        rd(OFS_CTRL_B, 32'h0);
        rd(OFS_SEL, 32'h0);
        rd(OFS_POWER, 32'h0);
        rd(8'h18, 32'h0, 1'b1, RESP_SLVERR);
        wr(8'h18, 8'hFF, RESP_SLVERR);
        tend("reset");
        wr(OFS_SEL, 8'h05);
        chk("chan off", 32'h0, 32'(core_channel));
        wr(OFS_POWER, 8'h01);
        wr(OFS_CTRL_A, 8'h88);
        chk("power gated", 32'h0, 32'(core_power));
        wr(OFS_POWER, 8'h00);
        repeat (2) @(posedge aclk);
        chk("power on", 32'h1, 32'(core_power));
        chk("chan on", 32'h5, 32'(core_channel));
        tend("power");
        newv();
        v = {5'h05, x[4:0]};
        wr(OFS_CTRL_A, 8'hC8);
        rd(OFS_CTRL_A, 32'h0, 1'b0);
        chk("busy", 32'h1, 32'(last[CA_START]));
        wdn();
        chk("first len", 32'(FST), 32'(len));
        chk("irq", 32'h1, 32'(conv_irq));
        rd(OFS_CTRL_A, 32'h98);
        rd(OFS_RES_LOW, lo(v, 1'b0));
        newv();
        wr(OFS_CTRL_A, 8'hD8);
        wdn();
        chk("normal len", 32'(NRM), 32'(len));
        chk("irq lost", 32'h1, 32'(conv_irq));
        rd(OFS_RES_HIGH, hi(v, 1'b0));
        rd(OFS_RES_LOW, lo(v, 1'b0));
        rd(OFS_RES_HIGH, hi(v, 1'b0));
        wr(OFS_SEL, 8'h25);
        newv();
        v = {5'h05, x[4:0]};
        wr(OFS_CTRL_A, 8'hD8);
        wdn();
        rd(OFS_RES_LOW, lo(v, 1'b1));
        rd(OFS_RES_HIGH, hi(v, 1'b1));
        wr(OFS_CTRL_A, 8'h90);
        chk("irq off", 32'h0, 32'(conv_irq));
        tend("result");
        wr(OFS_CTRL_A, 8'hC0);
        wr(OFS_SEL, 8'h07);
        chk("chan hold", 32'h5, 32'(core_channel));
        wdn();
        repeat (2) @(posedge aclk);
        chk("chan new", 32'h7, 32'(core_channel));
        for (int i = 0; i < 6; i++) begin
            wr(OFS_SEL, {i[1:0], 1'b0, chs[i]});
            repeat (2) @(posedge aclk);
            chk("gain", 32'(gns[i]), 32'(core_gain));
            chk("chan", 32'(chs[i]), 32'(core_channel));
            chk("ref", 32'(i[1:0]), 32'(core_reference));
        end
        tend("select");
        wr(OFS_CTRL_B, 8'h03);
        wr(OFS_CTRL_A, 8'hA0);
        s0 = nst;
        trig_in[3] <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFS_CTRL_A, 32'h0, 1'b0);
        chk("trig busy", 32'h1, 32'(last[CA_START]));
        trig_in[3] <= 1'b0;
        @(posedge aclk);
        trig_in[3] <= 1'b1;
        wdn();
        chk("trig len", 32'(NRM), 32'(len));
        repeat (3 * NRM) @(posedge aclk);
        chk("no retrigger", 32'(s0 + 1), 32'(nst));
        trig_in[3] <= 1'b0;
        @(posedge aclk);
        trig_in[3] <= 1'b1;
        wdn();
        chk("edge start", 32'(s0 + 2), 32'(nst));
        wr(OFS_CTRL_A, 8'hE0);
        wdn();
        chk("manual start", 32'(s0 + 3), 32'(nst));
        trig_in[3] <= 1'b0;
        tend("trigger");
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'hE0);
        wdn(3);
        rd(OFS_CTRL_A, 32'h0, 1'b0);
        chk("free busy", 32'h1, 32'(last[CA_START]));
        wr(OFS_CTRL_A, 8'h00);
        s0 = nst;
        repeat (4 * NRM) @(posedge aclk);
        chk("stopped", 32'(s0), 32'(nst));
        chk("power off", 32'h0, 32'(core_power));
        tend("free running");
        summarize();
    end
endmodule // sac_top_tb_top
